// ### design/fesp_pkg.sv
// Constants, opcodes, timing and state encoding for the flash erase, suspend and power-down sequencer.
// Assumes a 40 MHz core clock; link timing is taken from the serial clock itself.
package fesp_pkg;

  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_BLK_ERASE  = 8'hd8;
  localparam logic [7:0] OP_CHIP_A     = 8'hc7;
  localparam logic [7:0] OP_CHIP_B     = 8'h60;
  localparam logic [7:0] OP_SUSPEND    = 8'h75;
  localparam logic [7:0] OP_RESUME     = 8'h7a;
  localparam logic [7:0] OP_PWR_DOWN   = 8'hb9;
  localparam logic [7:0] OP_RELEASE    = 8'hab;
  localparam logic [7:0] OP_RD_STATUS  = 8'h05;
  localparam logic [7:0] OP_WR_EN      = 8'h06;
  localparam logic [7:0] OP_WR_DIS     = 8'h04;
  localparam logic [7:0] OP_WR_STATUS  = 8'h01;
  localparam logic [7:0] OP_SEC_ERASE  = 8'h20;
  localparam logic [7:0] OP_ERASE_32K  = 8'h52;
  localparam logic [7:0] OP_SREG_ERASE = 8'h44;
  localparam logic [7:0] OP_PROG       = 8'h02;
  localparam logic [7:0] OP_PROG_QUAD  = 8'h32;
  localparam logic [7:0] OP_SREG_PROG  = 8'h42;

  // ==========================================================
  // Frame lengths in serial clocks
  localparam logic [7:0] BITS_CMD  = 8'h08;
  localparam logic [7:0] BITS_ADDR = 8'h20;
  localparam logic [7:0] BITS_ID   = 8'h20;
  localparam logic [7:0] BITS_PROG = 8'h28;

  // ==========================================================
  // Array geometry and status byte layout
  localparam int unsigned BLK_COUNT   = 64;
  localparam int unsigned BLK_IDX_W   = 6;
  localparam int unsigned BLK_ADDR_LSB = 16;
  localparam int unsigned STAT_BUSY   = 0;
  localparam int unsigned STAT_WEL    = 1;
  localparam int unsigned STAT_SUS    = 7;

  // ==========================================================
  // Timing in ns and the core clock rate
  localparam int unsigned CLK_MHZ      = 40;
  localparam int unsigned RES_BUSY_NS  = 200;
  localparam int unsigned RES_BUSY_CYC = RES_BUSY_NS * CLK_MHZ / 1000;
  localparam int unsigned BLK_ERASE_NS = 150000;
  localparam int unsigned CHIP_ERASE_NS = 400000;
  localparam int unsigned PROG_NS      = 20000;
  localparam int unsigned PAUSE_LAT_NS = 20000;
  localparam int unsigned PD_ENTRY_NS  = 3000;
  localparam int unsigned WAKE_NS      = 3000;
  localparam int unsigned WAKE_ID_NS   = 5000;

  // ==========================================================
  // Operation kinds and sequencer states
  localparam logic [1:0] K_BLK  = 2'h0;
  localparam logic [1:0] K_CHIP = 2'h1;
  localparam logic [1:0] K_PROG = 2'h2;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'b0000001,
    ST_RUN    = 7'b0000010,
    ST_PAUSING = 7'b0000100,
    ST_PAUSED = 7'b0001000,
    ST_PD_ENT = 7'b0010000,
    ST_PD     = 7'b0100000,
    ST_WAKE   = 7'b1000000
  } fesp_state_e;

endpackage : fesp_pkg

// ### design/fesp_ctl.sv
// Serial flash command sequencer: block/chip erase, suspend/resume, power-down and identifier readout.
// Assumes a host driving chip select and serial clock; protection inputs are stable in the core clock domain.
module fesp_ctl #(
  parameter int unsigned BLK_CYC     = (fesp_pkg::BLK_ERASE_NS * fesp_pkg::CLK_MHZ + 999) / 1000,
  parameter int unsigned CHIP_CYC    = (fesp_pkg::CHIP_ERASE_NS * fesp_pkg::CLK_MHZ + 999) / 1000,
  parameter int unsigned PROG_CYC    = (fesp_pkg::PROG_NS * fesp_pkg::CLK_MHZ + 999) / 1000,
  parameter int unsigned PAUSE_CYC   = fesp_pkg::PAUSE_LAT_NS * fesp_pkg::CLK_MHZ / 1000,
  parameter int unsigned PD_CYC      = (fesp_pkg::PD_ENTRY_NS * fesp_pkg::CLK_MHZ + 999) / 1000,
  parameter int unsigned WAKE_CYC    = (fesp_pkg::WAKE_NS * fesp_pkg::CLK_MHZ + 999) / 1000,
  parameter int unsigned WAKE_ID_CYC = (fesp_pkg::WAKE_ID_NS * fesp_pkg::CLK_MHZ + 999) / 1000,
  parameter logic [7:0]  DEVICE_ID   = 8'h5a // Arbitrary identifier value
) (
  // Core clock and reset
  input  wire logic                             clk_in,
  input  wire logic                             rst_in,
  // Serial link
  input  wire logic                             sck_in,
  input  wire logic                             cs_n_in,
  input  wire logic                             mosi_in,
  output logic                                  miso_out,
  output logic                                  miso_oe_out,
  // Protection configuration
  input  wire logic                             protect_invert_in,
  input  wire logic                             small_unit_protect_in,
  input  wire logic                             top_bottom_select_in,
  input  wire logic                             protect_level_hi_in,
  input  wire logic                             protect_level_mid_in,
  input  wire logic                             protect_level_lo_in,
  input  wire logic [fesp_pkg::BLK_COUNT-1:0]   block_lock_in,
  // Status
  output logic                                  busy_out,
  output logic                                  write_latch_flag_out,
  output logic                                  pause_state_flag_out,
  output logic                                  power_down_out,
  // Array erase strobes
  output logic                                  erase_blk_out,
  output logic                                  erase_chip_out,
  output logic [fesp_pkg::BLK_IDX_W-1:0]        erase_idx_out
);
  import fesp_pkg::*;

  localparam int RES_MAX = RES_BUSY_CYC;

  // ==========================================================
  // Functions
  // Protection of one 64 KB block by level bits and locks
  function automatic logic blk_prot(input logic [5:0] b, input logic [63:0] lock);
    logic [5:0] from_end;
    logic [2:0] bp;
    logic       inr;
    from_end = top_bottom_select_in ? b : ~b;
    bp = {protect_level_hi_in, protect_level_mid_in, protect_level_lo_in};
    if (small_unit_protect_in)
      inr = protect_invert_in || (bp != 3'h0 && from_end == 6'h00);
    else
      inr = protect_invert_in ^ ((bp == 3'h7) ||
            (bp != 3'h0 && {1'b0, from_end} < (7'h01 << (bp - 3'h1))));
    return inr | lock[b];
  endfunction : blk_prot

  // Opcodes refused while an operation is paused
  function automatic logic is_blocked(input logic [7:0] op, input logic [1:0] kind);
    logic erase_op;
    logic prog_op;
    erase_op = op == OP_SEC_ERASE || op == OP_ERASE_32K || op == OP_BLK_ERASE ||
               op == OP_CHIP_A || op == OP_CHIP_B || op == OP_SREG_ERASE;
    prog_op  = op == OP_PROG || op == OP_PROG_QUAD || op == OP_SREG_PROG;
    return op == OP_WR_STATUS || (kind == K_PROG ? prog_op : erase_op);
  endfunction : is_blocked

  // ==========================================================
  // Link domain: frame capture on the serial clock
  logic        frame_rst;
  logic        started;
  logic [7:0]  bit_cnt;
  logic [31:0] shift_in;
  logic [7:0]  op_lk;
  logic        frame_tgl;
  logic [8:0]  stat_lk1;
  logic [8:0]  stat_lk2;

  // Chip select high ends the frame-scoped state
  assign frame_rst = rst_in | cs_n_in;

  // First-edge marker of a frame
  always_ff @(posedge sck_in or posedge frame_rst)
  begin
    if (frame_rst)
      started <= 1'b0;
    else
      started <= 1'b1;
  end

  // Input shifting on every rising serial clock edge and bit counting that holds at 255; both static while the serial clock stands still
  always_ff @(posedge sck_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      bit_cnt   <= 8'h00;
      shift_in  <= 32'h0;
      op_lk     <= 8'h00;
      frame_tgl <= 1'b0;
    end
    else
    begin
      shift_in <= {shift_in[30:0], mosi_in};
      if (!started)
      begin
        bit_cnt   <= 8'h01;
        frame_tgl <= ~frame_tgl;
      end
      else if (bit_cnt != 8'hff)
        bit_cnt <= bit_cnt + 8'h01;
      if (started && bit_cnt == BITS_CMD - 8'h01)
        op_lk <= {shift_in[6:0], mosi_in};
    end
  end

  // Status and power-down level into the link domain
  always_ff @(posedge sck_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      stat_lk1 <= 9'h0;
      stat_lk2 <= 9'h0;
    end
    else
    begin
      stat_lk1 <= {power_down_out, pause_state_flag_out, 5'h00, write_latch_flag_out, busy_out};
      stat_lk2 <= stat_lk1;
    end
  end

  // Output shifting on falling edges, MSB first, repeating each byte
  always_ff @(negedge sck_in or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      miso_out    <= 1'b0;
      miso_oe_out <= 1'b0;
    end
    else if (started && op_lk == OP_RD_STATUS && bit_cnt >= BITS_CMD && !stat_lk2[8])
    begin
      miso_out    <= stat_lk2[~bit_cnt[2:0]];
      miso_oe_out <= 1'b1;
    end
    else if (started && op_lk == OP_RELEASE && bit_cnt >= BITS_ID && !stat_lk2[STAT_BUSY])
    begin
      miso_out    <= DEVICE_ID[~bit_cnt[2:0]];
      miso_oe_out <= 1'b1;
    end
    else
    begin
      miso_out    <= 1'b0;
      miso_oe_out <= 1'b0;
    end
  end

  // ==========================================================
  // Core domain: chip select and frame marker synchronisers
  logic [2:0] cs_sync;
  logic       cs_high;
  logic [1:0] tgl_sync;
  logic       tgl_seen;
  logic       cs_rise;

  assign cs_rise = cs_sync[1] & cs_sync[2] & ~cs_high;

  // Chip select filter: a change counts when stages two and three agree
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cs_sync  <= 3'h7;
      cs_high  <= 1'b1;
      tgl_sync <= 2'h0;
      tgl_seen <= 1'b0;
    end
    else
    begin
      cs_sync  <= {cs_sync[1:0], cs_n_in};
      tgl_sync <= {tgl_sync[0], frame_tgl};
      if (cs_sync[1] == cs_sync[2])
        cs_high <= cs_sync[2];
      if (cs_rise)
        tgl_seen <= tgl_sync[1];
    end
  end

  // ==========================================================
  // Command decode at chip select rise
  fesp_state_e st;
  logic [1:0]  kind;
  logic [31:0] rem;
  logic [31:0] tmr;
  logic        wake_id;
  logic        ev;
  logic        idle_wel;
  logic        blk_prot_now;
  logic        chip_prot;
  logic        start_blk;
  logic        start_chip;
  logic        start_prog;
  logic        do_sus;
  logic        do_res;
  logic        do_pd;
  logic        do_rel;
  logic        do_wen;
  logic        do_wdis;
  logic        susp_drop;
  logic        complete;

  // Protection of the addressed block and of the whole array
  always_comb
  begin
    blk_prot_now = blk_prot(shift_in[BLK_ADDR_LSB +: BLK_IDX_W], block_lock_in);
    chip_prot = 1'b0;
    for (int i = 0; i < BLK_COUNT; i++)
      chip_prot = chip_prot | blk_prot(6'(i), block_lock_in);
  end

  // Accepted commands; a frame with no clocks is not a command
  assign ev         = cs_rise && (tgl_sync[1] != tgl_seen);
  assign idle_wel   = ev && st == ST_IDLE && write_latch_flag_out;
  assign start_blk  = idle_wel && op_lk == OP_BLK_ERASE && bit_cnt == BITS_ADDR && !blk_prot_now;
  assign start_chip = idle_wel && (op_lk == OP_CHIP_A || op_lk == OP_CHIP_B) &&
                      bit_cnt == BITS_CMD && !chip_prot;
  assign start_prog = idle_wel && (op_lk == OP_PROG || op_lk == OP_PROG_QUAD) &&
                      bit_cnt >= BITS_PROG && bit_cnt[2:0] == 3'h0;
  assign do_sus     = ev && op_lk == OP_SUSPEND && bit_cnt == BITS_CMD && st == ST_RUN &&
                      kind != K_CHIP && !pause_state_flag_out;
  assign do_res     = ev && op_lk == OP_RESUME && bit_cnt == BITS_CMD && st == ST_PAUSED;
  assign do_pd      = ev && op_lk == OP_PWR_DOWN && bit_cnt == BITS_CMD && st == ST_IDLE;
  assign do_rel     = ev && op_lk == OP_RELEASE && st == ST_PD &&
                      (bit_cnt == BITS_CMD || bit_cnt >= BITS_ID);
  assign do_wen     = ev && op_lk == OP_WR_EN && bit_cnt == BITS_CMD && (st == ST_IDLE || st == ST_PAUSED);
  assign do_wdis    = ev && op_lk == OP_WR_DIS && bit_cnt == BITS_CMD && (st == ST_IDLE || st == ST_PAUSED);
  assign susp_drop  = ev && st == ST_PAUSED && is_blocked(op_lk, kind);
  assign complete   = st == ST_RUN && rem == 32'h0 && !do_sus;

  // ==========================================================
  // Sequencer state, operation counter and timer
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st      <= ST_IDLE;
      kind    <= K_BLK;
      rem     <= 32'h0;
      tmr     <= 32'h0;
      wake_id <= 1'b0;
    end
    else
    begin
      unique case (st)
        ST_IDLE:
        begin
          if (start_blk)
          begin
            st   <= ST_RUN;
            kind <= K_BLK;
            rem  <= BLK_CYC - 32'd1;
          end
          else if (start_chip)
          begin
            st   <= ST_RUN;
            kind <= K_CHIP;
            rem  <= CHIP_CYC - 32'd1;
          end
          else if (start_prog)
          begin
            st   <= ST_RUN;
            kind <= K_PROG;
            rem  <= PROG_CYC - 32'd1;
          end
          else if (do_pd)
          begin
            st  <= ST_PD_ENT;
            tmr <= PD_CYC - 32'd1;
          end
        end
        ST_RUN:
        begin
          if (do_sus)
          begin
            st  <= ST_PAUSING;
            tmr <= PAUSE_CYC - 32'd1;
          end
          else if (rem == 32'h0)
            st <= ST_IDLE;
          else
            rem <= rem - 32'd1;
        end
        ST_PAUSING:
        begin
          if (tmr == 32'h0)
            st <= ST_PAUSED;
          else
            tmr <= tmr - 32'd1;
        end
        ST_PAUSED:
        begin
          if (do_res)
            st <= ST_RUN;
        end
        ST_PD_ENT:
        begin
          if (tmr == 32'h0)
            st <= ST_PD;
          else
            tmr <= tmr - 32'd1;
        end
        ST_PD:
        begin
          if (do_rel)
          begin
            st      <= ST_WAKE;
            wake_id <= bit_cnt >= BITS_ID;
            tmr     <= (bit_cnt >= BITS_ID ? WAKE_ID_CYC : WAKE_CYC) - 32'd1;
          end
        end
        ST_WAKE:
        begin
          if (!cs_high)
            tmr <= (wake_id ? WAKE_ID_CYC : WAKE_CYC) - 32'd1;
          else if (tmr == 32'h0)
            st <= ST_IDLE;
          else
            tmr <= tmr - 32'd1;
        end
      endcase
    end
  end

  // Busy flag
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      busy_out <= 1'b0;
    else if (start_blk || start_chip || start_prog || do_res)
      busy_out <= 1'b1;
    else if (complete || (st == ST_PAUSING && tmr == 32'h0))
      busy_out <= 1'b0;
  end

  // Write latch flag
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      write_latch_flag_out <= 1'b0;
    else if (do_wen)
      write_latch_flag_out <= 1'b1;
    else if (do_wdis || complete)
      write_latch_flag_out <= 1'b0;
  end

  // Pause flag, cleared by reset so a later resume finds nothing to resume
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      pause_state_flag_out <= 1'b0;
    else if (do_sus)
      pause_state_flag_out <= 1'b1;
    else if (do_res)
      pause_state_flag_out <= 1'b0;
  end

  // Power-down indication, also covering the wake interval
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      power_down_out <= 1'b0;
    else if (st == ST_PD_ENT && tmr == 32'h0)
      power_down_out <= 1'b1;
    else if (st == ST_WAKE && cs_high && tmr == 32'h0)
      power_down_out <= 1'b0;
  end

  // Erase strobes to the array and the block index
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      erase_blk_out  <= 1'b0;
      erase_chip_out <= 1'b0;
      erase_idx_out  <= '0;
    end
    else
    begin
      erase_blk_out  <= complete && kind == K_BLK;
      erase_chip_out <= complete && kind == K_CHIP;
      if (start_blk)
        erase_idx_out <= shift_in[BLK_ADDR_LSB +: BLK_IDX_W];
    end
  end

  // ==========================================================
  // Checks
  logic [31:0] pause_age;
  logic [31:0] wake_run;

  // Cycles spent paused but still busy, and cycles of unbroken wake
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pause_age <= 32'h0;
      wake_run  <= 32'h0;
    end
    else
    begin
      pause_age <= (pause_state_flag_out && busy_out) ? pause_age + 32'd1 : 32'h0;
      wake_run  <= (st == ST_WAKE && cs_high) ? wake_run + 32'd1 : 32'h0;
    end
  end

  sequence s_go;
    busy_out && !pause_state_flag_out;
  endsequence

  a_start_wel: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(busy_out) |-> $past(write_latch_flag_out) || $past(pause_state_flag_out))
    else $error("Operation started without write latch");
  a_blk_unprot: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(busy_out) && !$past(pause_state_flag_out) && kind == K_BLK |-> !$past(blk_prot_now))
    else $error("Protected block erase started");
  a_done_clr_wel: assert property (@(posedge clk_in) disable iff (rst_in)
    erase_blk_out || erase_chip_out |-> !write_latch_flag_out && !busy_out)
    else $error("Write latch or busy left set after erase");
  a_chip_no_pause: assert property (@(posedge clk_in) disable iff (rst_in)
    st == ST_RUN && kind == K_CHIP |=> !pause_state_flag_out)
    else $error("Chip erase was paused");
  a_pause_now: assert property (@(posedge clk_in) disable iff (rst_in)
    do_sus |=> pause_state_flag_out && busy_out)
    else $error("Pause flag not set at suspend");
  a_pause_lat: assert property (@(posedge clk_in) disable iff (rst_in)
    pause_age <= PAUSE_CYC)
    else $error("Busy held past pause latency");
  a_resume_go: assert property (@(posedge clk_in) disable iff (rst_in)
    do_res |=> !pause_state_flag_out ##[0:RES_MAX] s_go)
    else $error("Resume did not restart operation");
  a_pause_drop: assert property (@(posedge clk_in) disable iff (rst_in)
    susp_drop |=> st == ST_PAUSED && pause_state_flag_out && !busy_out && $stable(write_latch_flag_out))
    else $error("Refused command disturbed paused state");
  a_pd_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
    st == ST_PD && !do_rel |=> st == ST_PD && power_down_out && !busy_out)
    else $error("Power-down left without release");
  a_wake_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    st == ST_IDLE && $past(st) == ST_WAKE |-> wake_run >= (wake_id ? WAKE_ID_CYC : WAKE_CYC))
    else $error("Wake ended before hold time");

endmodule : fesp_ctl

// ### verification/fesp_host.sv
// Host model of the serial link: sends one frame at a time and captures miso.
// Assumes mode 0 and a device that shifts out on the falling serial clock edge.
module fesp_host (
  // Link outputs
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      mosi_out,
  // Link inputs
  input  wire logic miso_in,
  input  wire logic miso_oe_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [47:0] rx;
  logic        oe_seen;
  initial
  begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // ==========================================================
  // One frame of n bits MSB first; the clock stands still outside it
  task automatic send(input logic [47:0] val, input int n);
    rx = '0;
    oe_seen = 1'b0;
    #3.3 cs_n_out = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      mosi_out = val[i];
      #7.5 sck_out = 1'b1;
      rx = {rx[46:0], miso_oe_in ? miso_in : ~rx[0]}; // Undriven line toggles
      oe_seen = oe_seen | miso_oe_in;
      #7.5 sck_out = 1'b0;
    end
    #7.5 cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
  endtask : send
endmodule : fesp_host

// ### verification/tb_flash_erase_suspend_powerdown_ctl.sv
// Self-checking bench for the erase, suspend and power-down sequencer with a flag model.
// Assumes the host model and shortened timing parameters.
module tb_flash_erase_suspend_powerdown_ctl;
  timeunit 1ns;
  timeprecision 100ps;
  import fesp_pkg::*;
  localparam logic [7:0] ID = 8'h3c; // Arbitrary identifier
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic sck, cs_n, mosi, miso, miso_oe, busy, write_latch_flag, pause, pd, eblk, echip;
  logic [5:0]  prot;
  logic [63:0] lock;
  logic [5:0]  idx, idx_seen;
  int err_total = 0;
  int n_tests = 0;
  int seed = 42707;
  int m_busy = 0, m_wel = 0, m_pause = 0, m_pd = 0, m_blk = 0, m_chip = 0, n_blk = 0, n_chip = 0;
  always #12.5 clk_in = ~clk_in;
  fesp_host u_host (.sck_out(sck), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso), .miso_oe_in(miso_oe));
  fesp_ctl #(.BLK_CYC(80), .CHIP_CYC(80), .PROG_CYC(80), .PAUSE_CYC(5), .PD_CYC(4), .WAKE_CYC(6),
    .WAKE_ID_CYC(9), .DEVICE_ID(ID)) dut (.clk_in(clk_in), .rst_in(rst_in), .sck_in(sck), .cs_n_in(cs_n),
    .mosi_in(mosi), .miso_out(miso), .miso_oe_out(miso_oe), .protect_invert_in(prot[5]),
    .small_unit_protect_in(prot[4]), .top_bottom_select_in(prot[3]), .protect_level_hi_in(prot[2]),
    .protect_level_mid_in(prot[1]), .protect_level_lo_in(prot[0]), .block_lock_in(lock), .busy_out(busy),
    .write_latch_flag_out(write_latch_flag), .pause_state_flag_out(pause), .power_down_out(pd), .erase_blk_out(eblk),
    .erase_chip_out(echip), .erase_idx_out(idx_seen));
  // Count completion pulses
  always @(posedge clk_in)
  begin
    n_blk <= n_blk + (eblk === 1'b1);
    n_chip <= n_chip + (echip === 1'b1);
  end
  // ==========================================================
  // Checking and run control
  task automatic print_verdict();
    if (err_total == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic flags();
    chk("flags", {m_busy[0], m_wel[0], m_pause[0], m_pd[0]}, {busy, write_latch_flag, pause, pd});
    chk("pulses", {m_blk[3:0], m_chip[3:0]}, {n_blk[3:0], n_chip[3:0]});
  endtask : flags
  task automatic cmd(input logic [47:0] v, input int n);
    u_host.send(v, n);
    repeat (10) @(posedge clk_in);
    #2;
  endtask : cmd
  task automatic wait_idle();
    for (int i = 0; i < 200 && busy !== 1'b0; i++)
      @(posedge clk_in);
    if (busy !== 1'b0)
    begin
      err_total++;
      $display("[FAIL] busy expected 0 seen %b", busy);
      print_verdict();
    end
    repeat (3) @(posedge clk_in);
    #2;
  endtask : wait_idle
  // ==========================================================
  // Main sequence
  initial
  begin
    prot = 6'h00;
    lock = 64'h0;
    repeat (3) @(posedge clk_in);
    #2 rst_in = 1'b0;
    idx = 6'($random(seed));
    cmd({OP_BLK_ERASE, 2'h0, idx, 16'h0}, 32);
    flags();
    cmd(OP_WR_EN, 8);
    m_wel = 1;
    cmd({OP_BLK_ERASE, 2'h0, idx, 16'h0} >> 1, 31);
    flags();
    cmd({OP_BLK_ERASE, 2'h0, idx, 16'h0}, 32);
    m_busy = 1;
    flags();
    chk("idx", 8'(idx), 8'(idx_seen));
    cmd(OP_RD_STATUS << 8, 16);
    cmd(OP_RD_STATUS << 8, 16);
    chk("status", 8'h03, u_host.rx[7:0]);
    wait_idle();
    {m_busy, m_wel, m_blk} = {32'd0, 32'd0, 32'd1};
    flags();
    lock[idx] = 1'b1;
    cmd(OP_WR_EN, 8);
    cmd({OP_BLK_ERASE, 2'h0, idx, 16'h0}, 32);
    m_wel = 1;
    flags();
    lock = 64'h0;
    prot = 6'h20;
    cmd({OP_BLK_ERASE, 2'h0, idx, 16'h0}, 32);
    flags();
    prot = {1'b0, 2'($random(seed)), 3'($random(seed)) | 3'h1};
    cmd(OP_CHIP_A, 8);
    flags();
    prot = 6'h00;
    cmd(OP_CHIP_B, 8);
    m_busy = 1;
    cmd(OP_SUSPEND, 8);
    flags();
    cmd({OP_RELEASE, 32'h0}, 40);
    chk("id_busy", 8'h00, 8'(u_host.oe_seen));
    flags();
    wait_idle();
    {m_busy, m_wel, m_chip} = {32'd0, 32'd0, 32'd1};
    flags();
    cmd(OP_WR_EN, 8);
    cmd({OP_BLK_ERASE, 24'h0}, 32);
    cmd(OP_SUSPEND, 8);
    {m_wel, m_pause} = {32'd1, 32'd1};
    flags();
    cmd({OP_BLK_ERASE, 24'h0}, 32);
    cmd(OP_WR_STATUS << 8, 16);
    flags();
    cmd(OP_RESUME, 8);
    {m_busy, m_pause} = {32'd1, 32'd0};
    flags();
    cmd(OP_SUSPEND, 8);
    {m_busy, m_pause} = {32'd0, 32'd1};
    flags();
    rst_in = 1'b1;
    @(posedge clk_in);
    #2 rst_in = 1'b0;
    cmd(OP_RESUME, 8);
    {m_wel, m_pause} = {32'd0, 32'd0};
    flags();
    cmd(OP_PWR_DOWN << 1, 9);
    flags();
    cmd(OP_PWR_DOWN, 8);
    m_pd = 1;
    flags();
    cmd(OP_RD_STATUS << 8, 16);
    chk("pd_status", 8'h00, 8'(u_host.oe_seen));
    cmd(OP_RELEASE, 8);
    repeat (8) @(posedge clk_in);
    m_pd = 0;
    flags();
    cmd(OP_PWR_DOWN, 8);
    cmd({OP_RELEASE, 32'h0}, 40);
    m_pd = 1;
    flags();
    repeat (8) @(posedge clk_in);
    m_pd = 0;
    flags();
    cmd({OP_RELEASE, 40'h0}, 48);
    chk("id", ID, u_host.rx[15:8]);
    chk("id_again", ID, u_host.rx[7:0]);
    cmd(OP_WR_EN, 8);
    cmd({OP_PROG, 32'h0}, 40);
    cmd(OP_SUSPEND, 8);
    {m_wel, m_pause} = {32'd1, 32'd1};
    cmd({OP_PROG, 32'h0}, 40);
    cmd(OP_WR_STATUS << 8, 16);
    flags();
    cmd(OP_RESUME, 8);
    wait_idle();
    {m_wel, m_pause} = {32'd0, 32'd0};
    flags();
    print_verdict();
  end
endmodule : tb_flash_erase_suspend_powerdown_ctl
